// ==== include/tcg_pkg.sv ====
package tcg_pkg;

  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] TCG_OFS_CTRL = 8'h00; // timer_control
  localparam logic [7:0] TCG_OFS_GATE = 8'h04; // timer_gate_control
  localparam logic [7:0] TCG_OFS_COUNT = 8'h08; // Counter value, read only
  localparam logic [7:0] TCG_OFS_STAT = 8'h0C; // Event status, clear on read
  localparam logic [7:0] TCG_OFS_MASK = 8'h10; // Event mask

  // ------------------------------------------------------------
  // timer_control fields
  // ------------------------------------------------------------
  localparam int TCG_CS_HI = 7; // count_clock_select
  localparam int TCG_CS_LO = 6;
  localparam int TCG_PS_HI = 5; // input_prescale_select
  localparam int TCG_PS_LO = 4;
  localparam int TCG_OSC_BIT = 3; // dedicated_osc_enable
  localparam int TCG_SYNC_BIT = 2; // sync_bypass
  localparam int TCG_ON_BIT = 0; // counter_on
  localparam logic [7:0] TCG_CTRL_WMASK = 8'hFD; // Bit 1 unimplemented
  localparam logic [7:0] TCG_CTRL_RST = 8'h00;

  // ------------------------------------------------------------
  // timer_gate_control fields
  // ------------------------------------------------------------
  localparam int TCG_GE_BIT = 7; // gate_enable
  localparam int TCG_POL_BIT = 6; // gate_polarity
  localparam int TCG_TM_BIT = 5; // gate_toggle_mode
  localparam int TCG_SPM_BIT = 4; // gate_single_pulse_mode
  localparam int TCG_GO_BIT = 3; // single_pulse_arm_done
  localparam int TCG_VAL_BIT = 2; // gate_level, read only
  localparam logic [7:0] TCG_GATE_WMASK = 8'hFB;
  localparam logic [7:0] TCG_GATE_RST = 8'h00;

  // Status and mask layout
  localparam int TCG_EV_GATE_BIT = 0; // gate_event_flag
  localparam logic [7:0] TCG_EV_MASK = 8'h01;

  // ------------------------------------------------------------
  // Clock source codes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    TCG_SRC_INSTR = 2'b00, // System clock divided by four
    TCG_SRC_SYS = 2'b01, // Every system clock
    TCG_SRC_PIN = 2'b10, // External pin or dedicated oscillator
    TCG_SRC_CAP = 2'b11 // cap_sense_clock
  } tcg_src_t;

  // Instruction clock divider, last count of a divide by four
  localparam logic [1:0] TCG_INSTR_LAST = 2'h3;

  // Prescaler last counts for 1:1, 1:2, 1:4, 1:8
  localparam logic [2:0] TCG_PS_LAST_1 = 3'h0;
  localparam logic [2:0] TCG_PS_LAST_2 = 3'h1;
  localparam logic [2:0] TCG_PS_LAST_4 = 3'h3;
  localparam logic [2:0] TCG_PS_LAST_8 = 3'h7;

endpackage

// ==== hw/tcg_prescale.sv ====
`timescale 1ns/1ps
// Input prescaler: passes one tick out of 1, 2, 4 or 8
module tcg_prescale (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic tick_in,
  input wire logic [1:0] ratio,
  output logic tick_out
);

  logic [2:0] cnt_r; // Ticks seen since the last pass
  logic [2:0] last; // Last count for the chosen ratio

  // ------------------------------------------------------------
  // Ratio decode
  // ------------------------------------------------------------
  always_comb begin
    case (ratio)
      2'b11: last = tcg_pkg::TCG_PS_LAST_8;
      2'b10: last = tcg_pkg::TCG_PS_LAST_4;
      2'b01: last = tcg_pkg::TCG_PS_LAST_2;
      default: last = tcg_pkg::TCG_PS_LAST_1;
    endcase
  end

  // Greater-or-equal so a ratio lowered mid-count cannot hang it
  assign tick_out = tick_in && (cnt_r >= last);

  // ------------------------------------------------------------
  // Tick counter
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst || clear) begin
      cnt_r <= 3'h0;
    end else if (tick_out) begin
      cnt_r <= 3'h0;
    end else if (tick_in) begin
      cnt_r <= cnt_r + 3'h1;
    end
  end

endmodule // tcg_prescale

// ==== hw/tcg_timer.sv ====
`timescale 1ns/1ps
module tcg_timer (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_clk_i,
  input wire logic cap_sense_clock_i,
  input wire logic gate_pin_i,
  input wire logic gate_alt_i,
  output logic osc_enable_o,
  output logic gate_level_o,
  output logic [15:0] count_o,
  output logic irq_o
);

  // ------------------------------------------------------------
  // Address decode helper
  // ------------------------------------------------------------
  function automatic logic tcg_hit(input logic [7:0] adr, input logic [7:0] ofs);
    tcg_hit = (adr[7:2] == ofs[7:2]);
  endfunction

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [7:0] ctrl_r; // timer_control
  logic [7:0] gate_r; // timer_gate_control writable part
  logic go_r; // single_pulse_arm_done
  logic [7:0] stat_r; // Sticky events
  logic [7:0] mask_r; // Event mask
  logic [15:0] count_r; // Counter
  logic [1:0] div_r; // Instruction clock divider
  logic [1:0] sync1_r; // First sync stage, pin and cap clocks
  logic [1:0] sync2_r; // Second sync stage
  logic src_prev_r; // Previous selected clock level
  logic gate_open_r; // Gate after polarity
  logic tog_r; // Gate toggle flop
  logic tg_prev_r; // Previous toggle-stage gate
  logic sp_win_r; // Single-pulse window open
  logic gate_level_r; // Processed gate level
  logic irq_r;
  logic ack_r;
  logic [31:0] dat_r;
  logic req; // Fresh bus request
  logic wr; // Write strobe this cycle
  logic rd_stat; // Status read this cycle
  logic instr_tick; // Divide-by-four enable
  logic [1:0] raw_src; // Pin and cap clock raw
  logic src_lvl; // Chosen async level
  logic src_tick; // Tick of chosen source
  logic ps_tick; // Prescaled tick
  logic on; // counter_on
  logic count_en; // Counting allowed
  logic gate_raw; // Gate source
  logic gate_open; // Gate after polarity
  logic open_rise;
  logic tg; // Gate after toggle stage
  logic tg_rise;
  logic level_nxt; // Next processed gate level
  logic gate_fall; // Trailing edge of processed gate
  logic go_set; // Software arms the pulse
  logic [7:0] stat_nxt;

  assign on = ctrl_r[tcg_pkg::TCG_ON_BIT];
  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign rd_stat = req && !wb_we_i && tcg_hit(wb_adr_i, tcg_pkg::TCG_OFS_STAT);

  // ------------------------------------------------------------
  // Bus slave: one wait state, ack for every address
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req;
    end
  end

  // Read data is latched with the ack; unmapped addresses read zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      dat_r <= 32'h0000_0000;
    end else if (req && !wb_we_i) begin
      if (tcg_hit(wb_adr_i, tcg_pkg::TCG_OFS_CTRL)) begin
        dat_r <= {24'h000000, ctrl_r & tcg_pkg::TCG_CTRL_WMASK};
      end else if (tcg_hit(wb_adr_i, tcg_pkg::TCG_OFS_GATE)) begin
        dat_r <= {24'h000000, gate_r[7:4], go_r, gate_level_r, gate_r[1:0]};
      end else if (tcg_hit(wb_adr_i, tcg_pkg::TCG_OFS_COUNT)) begin
        dat_r <= {16'h0000, count_r};
      end else if (rd_stat) begin
        dat_r <= {24'h000000, stat_r};
      end else if (tcg_hit(wb_adr_i, tcg_pkg::TCG_OFS_MASK)) begin
        dat_r <= {24'h000000, mask_r};
      end else begin
        dat_r <= 32'h0000_0000;
      end
    end
  end

  // ------------------------------------------------------------
  // Control registers
  // ------------------------------------------------------------
  // Bit 1 never stores, so it always reads back zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_r <= tcg_pkg::TCG_CTRL_RST;
    end else if (wr && tcg_hit(wb_adr_i, tcg_pkg::TCG_OFS_CTRL)) begin
      ctrl_r <= wb_dat_i[7:0] & tcg_pkg::TCG_CTRL_WMASK;
    end
  end

  // Gate control; the level bit is never stored here
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gate_r <= tcg_pkg::TCG_GATE_RST;
    end else if (wr && tcg_hit(wb_adr_i, tcg_pkg::TCG_OFS_GATE)) begin
      gate_r <= wb_dat_i[7:0] & tcg_pkg::TCG_GATE_WMASK;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mask_r <= 8'h00;
    end else if (wr && tcg_hit(wb_adr_i, tcg_pkg::TCG_OFS_MASK)) begin
      mask_r <= wb_dat_i[7:0] & tcg_pkg::TCG_EV_MASK;
    end
  end

  // Oscillator enable follows its control bit
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      osc_enable_o <= 1'b0;
    end else begin
      osc_enable_o <= ctrl_r[tcg_pkg::TCG_OSC_BIT];
    end
  end

  // ------------------------------------------------------------
  // Count clock selection
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      div_r <= 2'h0;
    end else begin
      div_r <= div_r + 2'h1;
    end
  end
  assign instr_tick = (div_r == tcg_pkg::TCG_INSTR_LAST);

  assign raw_src = {cap_sense_clock_i, ext_clk_i};

  // Two-stage synchronisers for the asynchronous clock sources
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          sync1_r[gi] <= 1'b0;
          sync2_r[gi] <= 1'b0;
        end else begin
          sync1_r[gi] <= raw_src[gi];
          sync2_r[gi] <= sync1_r[gi];
        end
      end
    end
  endgenerate

  // Bypass trades metastability safety for two cycles less latency
  always_comb begin
    if (ctrl_r[tcg_pkg::TCG_SYNC_BIT]) begin
      src_lvl = raw_src[ctrl_r[tcg_pkg::TCG_CS_LO]];
    end else begin
      src_lvl = sync2_r[ctrl_r[tcg_pkg::TCG_CS_LO]];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      src_prev_r <= 1'b0;
    end else begin
      src_prev_r <= src_lvl;
    end
  end

  // Tick per selected clock
  always_comb begin
    case (tcg_pkg::tcg_src_t'(ctrl_r[tcg_pkg::TCG_CS_HI:tcg_pkg::TCG_CS_LO]))
      tcg_pkg::TCG_SRC_INSTR: src_tick = instr_tick;
      tcg_pkg::TCG_SRC_SYS: src_tick = 1'b1;
      tcg_pkg::TCG_SRC_PIN: src_tick = src_lvl && !src_prev_r;
      tcg_pkg::TCG_SRC_CAP: src_tick = src_lvl && !src_prev_r;
      default: src_tick = 1'b0;
    endcase
  end

  // Prescaler held cleared while the counter is off
  tcg_prescale u_prescale (
    .sys_clk(sys_clk),
    .rst(rst),
    .clear(!on),
    .tick_in(src_tick),
    .ratio(ctrl_r[tcg_pkg::TCG_PS_HI:tcg_pkg::TCG_PS_LO]),
    .tick_out(ps_tick)
  );

  // ------------------------------------------------------------
  // Gate processing
  // ------------------------------------------------------------
  assign gate_raw = (gate_r[1:0] == 2'b00) ? gate_pin_i : gate_alt_i;
  assign gate_open = gate_r[tcg_pkg::TCG_POL_BIT] ? gate_raw : !gate_raw;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gate_open_r <= 1'b0;
    end else begin
      gate_open_r <= gate_open;
    end
  end
  assign open_rise = gate_open && !gate_open_r;

  // Toggle flop: held clear outside toggle mode and while off
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tog_r <= 1'b0;
    end else if (!on) begin
      tog_r <= 1'b0;
    end else if (!gate_r[tcg_pkg::TCG_TM_BIT]) begin
      tog_r <= 1'b0;
    end else if (open_rise) begin
      tog_r <= !tog_r;
    end
  end

  assign tg = gate_r[tcg_pkg::TCG_TM_BIT] ? tog_r : gate_open_r;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      tg_prev_r <= 1'b0;
    end else begin
      tg_prev_r <= tg;
    end
  end
  assign tg_rise = tg && !tg_prev_r;

  // Single-pulse window opens on the first edge after arming
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sp_win_r <= 1'b0;
    end else if (!gate_r[tcg_pkg::TCG_SPM_BIT] || !go_r) begin
      sp_win_r <= 1'b0;
    end else if (tg_rise) begin
      sp_win_r <= 1'b1;
    end
  end

  assign level_nxt = gate_r[tcg_pkg::TCG_SPM_BIT] ? (tg && sp_win_r) : tg;
  assign gate_fall = gate_level_r && !level_nxt;

  // Processed level is valid whether or not gating is on
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      gate_level_r <= 1'b0;
      gate_level_o <= 1'b0;
    end else begin
      gate_level_r <= level_nxt;
      gate_level_o <= level_nxt;
    end
  end

  // Arm bit: software set wins over a trailing edge in the same cycle
  assign go_set = wr && tcg_hit(wb_adr_i, tcg_pkg::TCG_OFS_GATE)
                  && wb_dat_i[tcg_pkg::TCG_GO_BIT];
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      go_r <= 1'b0;
    end else if (wr && tcg_hit(wb_adr_i, tcg_pkg::TCG_OFS_GATE)) begin
      go_r <= wb_dat_i[tcg_pkg::TCG_GO_BIT];
    end else if (gate_r[tcg_pkg::TCG_SPM_BIT] && gate_fall) begin
      go_r <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Events and interrupt
  // ------------------------------------------------------------
  // A new event in the read cycle survives the clear-on-read
  always_comb begin
    stat_nxt = rd_stat ? 8'h00 : stat_r;
    stat_nxt[tcg_pkg::TCG_EV_GATE_BIT] = stat_nxt[tcg_pkg::TCG_EV_GATE_BIT] || gate_fall;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stat_r <= 8'h00;
      irq_r <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      irq_r <= |(stat_nxt & mask_r);
    end
  end

  // ------------------------------------------------------------
  // Counter
  // ------------------------------------------------------------
  // Gate enable only matters while the counter is on
  assign count_en = on && (!gate_r[tcg_pkg::TCG_GE_BIT] || gate_level_r);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      count_r <= 16'h0000;
    end else if (ps_tick && count_en) begin
      count_r <= count_r + 16'h0001;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;
  assign irq_o = irq_r;
  assign count_o = count_r;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  // Only control reads are watched; gate and count registers use bit 1 for data
  unused_bit_a: assert property (ack_r && $past(tcg_hit(wb_adr_i, tcg_pkg::TCG_OFS_CTRL)
                                 && !wb_we_i) |-> !dat_r[1])
    else $error("Unused control bit read as one");
  count_stop_a: assert property (!on |=> $stable(count_r))
    else $error("Counter moved while off");
  count_step_a: assert property (ps_tick && count_en |=> count_r == $past(count_r) + 16'h0001)
    else $error("Counter did not step by one");
  off_toggle_a: assert property (!on |=> !tog_r)
    else $error("Toggle flop not cleared while off");
  toggle_hold_a: assert property (!gate_r[tcg_pkg::TCG_TM_BIT] |=> !tog_r)
    else $error("Toggle flop set outside toggle mode");
  gate_block_a: assert property (on && gate_r[tcg_pkg::TCG_GE_BIT] && !gate_level_r
                                 |=> $stable(count_r))
    else $error("Counted with gate closed");
  free_run_a: assert property (on && !gate_r[tcg_pkg::TCG_GE_BIT] && ps_tick
                               |=> count_r != $past(count_r))
    else $error("Missed a tick with gate disabled");
  arm_done_a: assert property (gate_r[tcg_pkg::TCG_SPM_BIT] && go_r && gate_fall && !go_set
                               |=> !go_r)
    else $error("Arm bit not cleared on trailing edge");
  event_set_a: assert property (gate_fall |=> stat_r[tcg_pkg::TCG_EV_GATE_BIT])
    else $error("Gate event flag not set");
  osc_follow_a: assert property (ctrl_r[tcg_pkg::TCG_OSC_BIT] |=> osc_enable_o)
    else $error("Oscillator enable not driven");
  level_show_a: assert property (ack_r && $past(tcg_hit(wb_adr_i, tcg_pkg::TCG_OFS_GATE) && !wb_we_i)
                                 |-> dat_r[2] == $past(gate_level_r))
    else $error("Gate level read wrong");

  wrap_c: cover property (count_r == 16'hFFFF && ps_tick && count_en ##1 count_r == 16'h0000);
  pulse_c: cover property (gate_r[tcg_pkg::TCG_SPM_BIT] && go_r && gate_fall);
  toggle_c: cover property (on && gate_r[tcg_pkg::TCG_TM_BIT] && open_rise);
  irq_c: cover property (irq_r && rd_stat);

endmodule // tcg_timer

// ==== verification/tcg_ext_model.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Far side: count clock lines and gate inputs
// ------------------------------------------------------------
module tcg_ext_model (
  input wire logic sys_clk,
  input wire logic go, // Pulse: start a burst of clock edges
  input wire logic use_cap, // Burst on the cap clock line, else on the pin clock
  input wire logic [7:0] edges, // Rising edges in the burst
  input wire logic [2:0] half, // Half period in system cycles, 2 or more
  input wire logic gate_lvl, // Requested gate level
  output logic ext_clk,
  output logic cap_clk,
  output logic gate_pin,
  output logic gate_alt,
  output logic busy
);
  // Gate lines follow the request one cycle later
  always @(posedge sys_clk) begin
    gate_pin <= gate_lvl;
    gate_alt <= ~gate_lvl; // Opposite level, so a wrong gate source shows
  end

  // Clock bursts; both lines rest low between bursts
  initial begin
    {cap_clk, ext_clk} = 2'b00;
    busy = 1'b0;
    forever begin
      @(posedge sys_clk);
      if (go) begin
        busy <= 1'b1;
        repeat (edges) begin
          repeat (half) @(posedge sys_clk);
          {cap_clk, ext_clk} <= use_cap ? 2'b10 : 2'b01;
          repeat (half) @(posedge sys_clk);
          {cap_clk, ext_clk} <= 2'b00;
        end
        busy <= 1'b0;
      end
    end
  end
endmodule // tcg_ext_model

// ==== verification/tcg_timer_tb.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// Self-checking bench for the timer control and gate block
// ------------------------------------------------------------
module tcg_timer_tb;
  logic sys_clk; // 200 MHz
  logic rst;
  logic wb_cyc_i;
  logic wb_stb_i;
  logic wb_we_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic ext_clk_i;
  logic cap_sense_clock_i;
  logic gate_pin_i;
  logic gate_alt_i;
  logic osc_enable_o;
  logic gate_level_o;
  logic [15:0] count_o;
  logic irq_o;
  logic b_go; // Burst request to the far side
  logic b_cap;
  logic [7:0] b_edges;
  logic [2:0] b_half;
  logic b_busy;
  logic g_lvl; // Gate level asked of the far side
  int fail_count;
  int checked;
  int exp_count; // Reference counter value
  logic [31:0] rd; // Last read data

  tcg_timer i_tcg_timer (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_clk_i(ext_clk_i),
    .cap_sense_clock_i(cap_sense_clock_i), .gate_pin_i(gate_pin_i), .gate_alt_i(gate_alt_i),
    .osc_enable_o(osc_enable_o), .gate_level_o(gate_level_o), .count_o(count_o),
    .irq_o(irq_o));

  tcg_ext_model i_tcg_ext_model (.sys_clk(sys_clk), .go(b_go), .use_cap(b_cap),
    .edges(b_edges), .half(b_half), .gate_lvl(g_lvl), .ext_clk(ext_clk_i),
    .cap_clk(cap_sense_clock_i), .gate_pin(gate_pin_i), .gate_alt(gate_alt_i),
    .busy(b_busy));

  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %0h seen %0h", name, exp, seen);
    end
  endtask

  // ------------------------------------------------------------
  // Bus cycles: entered just after a rising edge
  // ------------------------------------------------------------
  task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] wd,
                    input logic [3:0] sel);
    int n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= sel;
    wb_dat_i <= {24'($urandom()), wd}; // Upper byte lanes carry noise
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    if (n >= 50) begin
      fail_count++;
      wrap_up();
    end
    rd = wb_dat_o; // Taken at the acknowledging edge
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge sys_clk); // Idle cycle between requests
  endtask

  task automatic wr(input logic [7:0] adr, input logic [7:0] wd);
    wb(1'b1, adr, wd, 4'hF);
  endtask

  task automatic rdc(input string name, input logic [7:0] adr, input logic [31:0] exp);
    wb(1'b0, adr, 8'h00, 4'hF);
    check(name, rd, exp);
  endtask

  task automatic cnt_check();
    rdc("count reg", tcg_pkg::TCG_OFS_COUNT, 32'(exp_count));
    check("count_o", {16'h0000, count_o}, 32'(exp_count));
  endtask

  // ------------------------------------------------------------
  // Far-side stimulus
  // ------------------------------------------------------------
  // Sixteen edges at a random rate; inc is what the counter should gain
  task automatic burst(input logic cap, input int inc);
    int k;
    b_cap <= cap;
    b_edges <= 8'h10;
    b_half <= 3'(2 + $urandom() % 4);
    b_go <= 1'b1;
    @(posedge sys_clk);
    b_go <= 1'b0;
    k = 0;
    do begin
      @(posedge sys_clk);
      k++;
    end while (b_busy === 1'b1 && k < 2000);
    if (k >= 2000) begin
      fail_count++;
      wrap_up();
    end
    repeat (6) @(posedge sys_clk); // Sync stages settle
    exp_count += inc;
  endtask

  // Gate path lags a few cycles, so leave room after each change
  task automatic set_gate(input logic lvl);
    g_lvl <= lvl;
    repeat (8) @(posedge sys_clk);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin : main
    logic [1:0] src;
    logic cap;
    logic ge;
    logic pol;
    logic pin;
    int r; // Internal-source run, in groups of four cycles
    {rst, wb_cyc_i, wb_stb_i, wb_we_i, b_go, b_cap, g_lvl} = 7'h41;
    {wb_adr_i, wb_sel_i, wb_dat_i, b_edges, b_half} = '0;
    {fail_count, checked, exp_count} = '0;
    void'($urandom(80165));
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rdc("ctrl reset", tcg_pkg::TCG_OFS_CTRL, 32'h0);
    rdc("gate reset", tcg_pkg::TCG_OFS_GATE, 32'h0);
    cnt_check();
    // Refused writes: unmapped place and disabled byte lane
    wr(8'h14, 8'hFF);
    rdc("unmapped", 8'h14, 32'h0);
    wb(1'b1, tcg_pkg::TCG_OFS_MASK, 8'h01, 4'hE);
    rdc("mask lane off", tcg_pkg::TCG_OFS_MASK, 32'h0);
    wr(tcg_pkg::TCG_OFS_CTRL, 8'h0E);
    rdc("ctrl unused bit", tcg_pkg::TCG_OFS_CTRL, 32'h0C);
    check("osc on", {31'h0, osc_enable_o}, 32'h1);
    wr(tcg_pkg::TCG_OFS_CTRL, 8'h00);
    check("osc off", {31'h0, osc_enable_o}, 32'h0);
    // Every prescale code, both sync settings, random source and line
    for (int i = 0; i < 8; i++) begin
      src = 2'b10 | 2'($urandom() % 2);
      cap = 1'($urandom() % 2);
      wr(tcg_pkg::TCG_OFS_CTRL, {src, i[1:0], 1'b0, i[2], 2'b01});
      burst(cap, (cap == src[0]) ? (16 >> i[1:0]) : 0);
      wr(tcg_pkg::TCG_OFS_CTRL, {src, i[1:0], 1'b0, i[2], 2'b00});
      burst(cap, 0);
      cnt_check();
    end
    // Internal sources: on for 4r edges gives r ticks at sys/4, 2r at sys with 1:2
    for (int s = 0; s < 2; s++) begin
      r = 2 + $urandom() % 8;
      wr(tcg_pkg::TCG_OFS_CTRL, {1'b0, s[0], 1'b0, s[0], 4'h1});
      repeat (4 * r - 3) @(posedge sys_clk);
      wr(tcg_pkg::TCG_OFS_CTRL, 8'h00);
      exp_count += (s == 1) ? 2 * r : r;
      cnt_check();
    end
    // Gate enable, polarity and level
    for (int j = 0; j < 5; j++) begin
      ge = (j < 4);
      pol = ~j[1];
      pin = j[0];
      wr(tcg_pkg::TCG_OFS_GATE, {ge, pol, 6'h00});
      set_gate(pin);
      check("gate level", {31'h0, gate_level_o}, {31'h0, pin ~^ pol});
      wr(tcg_pkg::TCG_OFS_CTRL, 8'h81);
      burst(1'b0, (!ge || pin == pol) ? 16 : 0);
      wr(tcg_pkg::TCG_OFS_CTRL, 8'h80);
      cnt_check();
    end
    // Gate event flag, mask and interrupt line
    wr(tcg_pkg::TCG_OFS_GATE, 8'h40);
    set_gate(1'b1);
    wb(1'b0, tcg_pkg::TCG_OFS_STAT, 8'h00, 4'hF); // Flush earlier events
    wr(tcg_pkg::TCG_OFS_MASK, 8'h01);
    set_gate(1'b0);
    check("irq set", {31'h0, irq_o}, 32'h1);
    rdc("status", tcg_pkg::TCG_OFS_STAT, 32'h1);
    rdc("status cleared", tcg_pkg::TCG_OFS_STAT, 32'h0);
    check("irq clear", {31'h0, irq_o}, 32'h0);
    wr(tcg_pkg::TCG_OFS_MASK, 8'h00);
    set_gate(1'b1);
    set_gate(1'b0);
    check("irq masked", {31'h0, irq_o}, 32'h0);
    rdc("status masked", tcg_pkg::TCG_OFS_STAT, 32'h1);
    // Toggle mode: one count window spans a full gate cycle
    wr(tcg_pkg::TCG_OFS_GATE, 8'hE0);
    wr(tcg_pkg::TCG_OFS_CTRL, 8'h81);
    for (int p = 0; p < 3; p++) begin
      set_gate(1'b1);
      set_gate(1'b0);
      check("toggle level", {31'h0, gate_level_o}, 32'(p % 2 == 0));
      if (p < 2) burst(1'b0, (p == 0) ? 16 : 0);
    end
    wr(tcg_pkg::TCG_OFS_CTRL, 8'h80);
    repeat (2) @(posedge sys_clk); // Flop clear, then the level stage
    check("toggle off", {31'h0, gate_level_o}, 32'h0);
    cnt_check();
    // Single pulse: arm, one window, then closed until re-armed
    wr(tcg_pkg::TCG_OFS_GATE, 8'hD0);
    wr(tcg_pkg::TCG_OFS_CTRL, 8'h81);
    wr(tcg_pkg::TCG_OFS_GATE, 8'hD8);
    rdc("armed", tcg_pkg::TCG_OFS_GATE, 32'hD8);
    set_gate(1'b1);
    burst(1'b0, 16);
    set_gate(1'b0);
    rdc("done", tcg_pkg::TCG_OFS_GATE, 32'hD0);
    set_gate(1'b1);
    burst(1'b0, 0);
    set_gate(1'b0);
    wr(tcg_pkg::TCG_OFS_CTRL, 8'h80);
    cnt_check();
    wrap_up();
  end
endmodule // tcg_timer_tb
